/* rtl/pms_ctrl.sv */
// profile pin modulation select and linear amplitude sweep controller
`timescale 1ns/100ps
`default_nettype none
`include "pms_defines.svh"
// Summary of operation
// - in 16-level mode index = {pin0,pin1,pin2,pin3}, pin3 the lowest bit.
// - no pins asserted selects profile zero, the base tuning word.
// - all pins asserted selects profile fifteen.
// - a channel sweeps only while its sweep enable bit is set.
// - sweep starts at the scale factor and ends at profile one amplitude.
// - pin asserted sweeps up toward end; deasserted sweeps down to start.
// - rising and falling step size and interval are independent.
// - scale factor enable must be clear while sweeping, sweep owns amplitude.
// - auto clear phase asserts phase_clr_out while both channels hold; auto clear sweep never changes the amplitude.
// - profile_pin_2 steers channel 0, profile_pin_3 steers channel 1.
module pms_ctrl
    import pms_pkg::*;
(
    input  wire logic                     mclk_in,
    input  wire logic                     reset_n_in,
    input  wire logic                     profile_pin_0_in,
    input  wire logic                     profile_pin_1_in,
    input  wire logic                     profile_pin_2_in,
    input  wire logic                     profile_pin_3_in,
    input  wire logic [`PMS_ADDR_W-1:0]   addr_in,
    input  wire logic [31:0]              wdata_in,
    input  wire logic                     wr_in,
    input  wire logic                     rd_in,
    output logic      [31:0]              rdata_out,
    output logic      [`PMS_FTW_W-1:0]    ftw_out,
    output logic      [`PMS_AMP_W-1:0]    amp0_out,
    output logic      [`PMS_AMP_W-1:0]    amp1_out,
    output logic                          phase_clr_out
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta;
    logic rst_n;
    // release synchronised, assertion asynchronous
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [`PMS_CTRL_W-1:0]  ctrl;
        logic [`PMS_AMP_W-1:0]   asf0;
        logic [`PMS_AMP_W-1:0]   asf1;
        logic [`PMS_AMP_W-1:0]   rstep;
        logic [`PMS_AMP_W-1:0]   fstep;
        logic [`PMS_IVL_W-1:0]   rivl;
        logic [`PMS_IVL_W-1:0]   fivl;
        logic [`PMS_IDX_W-1:0]   pins;
        logic [`PMS_IDX_W-1:0]   index;
        logic [`PMS_FTW_W-1:0]   ftw;
        logic [`PMS_AMP_W-1:0]   amp0;
        logic [`PMS_AMP_W-1:0]   amp1;
        logic [`PMS_IVL_W-1:0]   tmr0;
        logic [`PMS_IVL_W-1:0]   tmr1;
        pms_dir_type             dir0;
        pms_dir_type             dir1;
        logic                    pclr;
        logic [31:0]             rdata;
    } pms_state_type;

    pms_state_type st;
    pms_state_type next_st;
    // profile tables are large, kept outside the struct as plain arrays
    logic [`PMS_FTW_W-1:0] ftw_mem [`PMS_NPROF];
    logic [`PMS_AMP_W-1:0] pamp_mem [`PMS_NCH];

    logic [`PMS_IDX_W-1:0] pin_vec;
    // pin 0 carries the highest weight, pin 3 the lowest
    assign pin_vec = {profile_pin_0_in, profile_pin_1_in, profile_pin_2_in, profile_pin_3_in};

    // profile words, one write port each
    genvar gi;
    generate
        for (gi = 0; gi < `PMS_NPROF; gi++) begin : g_ftw
            always_ff @(posedge mclk_in or negedge rst_n) begin
                if (!rst_n) begin
                    ftw_mem[gi] <= '0;
                end else if (wr_in && addr_in == `PMS_ADR_FTW + 8'(gi)) begin
                    ftw_mem[gi] <= wdata_in[`PMS_FTW_W-1:0];
                end
            end
        end
        for (gi = 0; gi < `PMS_NCH; gi++) begin : g_pamp
            always_ff @(posedge mclk_in or negedge rst_n) begin
                if (!rst_n) begin
                    pamp_mem[gi] <= '0;
                end else if (wr_in && addr_in == `PMS_ADR_PAMP0 + 8'(gi)) begin
                    pamp_mem[gi] <= wdata_in[`PMS_AMP_W-1:0];
                end
            end
        end
    endgenerate

    // one sweep step; saturates at the bound so no wrap past start or end
    function automatic logic [`PMS_AMP_W-1:0] step_amp(
        input logic [`PMS_AMP_W-1:0] cur,
        input logic [`PMS_AMP_W-1:0] bound,
        input logic [`PMS_AMP_W-1:0] stp,
        input logic                  up
    );
        logic [`PMS_AMP_W:0] sum;
        sum = '0;
        if (up) begin
            sum = {1'b0, cur} + {1'b0, stp};
            step_amp = (sum >= {1'b0, bound}) ? bound : sum[`PMS_AMP_W-1:0];
        end else begin
            // widened so a start point near full scale plus a step cannot wrap
            step_amp = ({1'b0, cur} <= {1'b0, bound} + {1'b0, stp}) ? bound : cur - stp;
        end
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic dir_pin0;
        logic dir_pin1;
        logic sw0;
        logic sw1;
        next_st = st;
        dir_pin0 = st.pins[1]; // profile_pin_2
        dir_pin1 = st.pins[0]; // profile_pin_3
        sw0 = st.ctrl[`PMS_BIT_SWEEP0] && !st.ctrl[`PMS_BIT_ASFEN];
        sw1 = st.ctrl[`PMS_BIT_SWEEP1] && !st.ctrl[`PMS_BIT_ASFEN];
        next_st.pins = pin_vec;
        // index follows the sampled pins one cycle later
        if (st.ctrl[`PMS_BIT_MOD16]) begin
            next_st.index = st.pins;
        end
        next_st.ftw = ftw_mem[st.index];
        next_st.pclr = st.ctrl[`PMS_BIT_ACLRP] && (st.dir0 == PMS_HOLD) && (st.dir1 == PMS_HOLD);
        // channel 0 sweep
        if (!sw0) begin
            next_st.amp0 = st.asf0;
            next_st.dir0 = PMS_HOLD;
            next_st.tmr0 = '0;
        end else begin
            case (st.dir0)
                PMS_HOLD: begin
                    if (dir_pin0 && st.amp0 != pamp_mem[`PMS_PROF_ONE]) begin
                        next_st.dir0 = PMS_UP;
                    end else if (!dir_pin0 && st.amp0 != st.asf0) begin
                        next_st.dir0 = PMS_DOWN;
                    end else if (!dir_pin0 && st.ctrl[`PMS_BIT_ACLRS]) begin
                        next_st.amp0 = st.asf0;
                    end
                    next_st.tmr0 = '0;
                end
                default: begin
                    next_st.tmr0 = st.tmr0 + 8'h01;
                    if (dir_pin0 != (st.dir0 == PMS_UP)) begin
                        next_st.dir0 = PMS_HOLD;
                    end else if (st.tmr0 >= ((st.dir0 == PMS_UP) ? st.rivl : st.fivl)) begin
                        next_st.tmr0 = '0;
                        if (st.dir0 == PMS_UP) begin
                            next_st.amp0 = step_amp(st.amp0, pamp_mem[`PMS_PROF_ONE], st.rstep, 1'b1);
                        end else begin
                            next_st.amp0 = step_amp(st.amp0, st.asf0, st.fstep, 1'b0);
                        end
                        if (next_st.amp0 == ((st.dir0 == PMS_UP) ? pamp_mem[`PMS_PROF_ONE] : st.asf0)) begin
                            next_st.dir0 = PMS_HOLD;
                        end
                    end
                end
            endcase
        end
        // channel 1 sweep
        if (!sw1) begin
            next_st.amp1 = st.asf1;
            next_st.dir1 = PMS_HOLD;
            next_st.tmr1 = '0;
        end else begin
            case (st.dir1)
                PMS_HOLD: begin
                    if (dir_pin1 && st.amp1 != pamp_mem[`PMS_PROF_ONE]) begin
                        next_st.dir1 = PMS_UP;
                    end else if (!dir_pin1 && st.amp1 != st.asf1) begin
                        next_st.dir1 = PMS_DOWN;
                    end else if (!dir_pin1 && st.ctrl[`PMS_BIT_ACLRS]) begin
                        next_st.amp1 = st.asf1;
                    end
                    next_st.tmr1 = '0;
                end
                default: begin
                    next_st.tmr1 = st.tmr1 + 8'h01;
                    if (dir_pin1 != (st.dir1 == PMS_UP)) begin
                        next_st.dir1 = PMS_HOLD;
                    end else if (st.tmr1 >= ((st.dir1 == PMS_UP) ? st.rivl : st.fivl)) begin
                        next_st.tmr1 = '0;
                        if (st.dir1 == PMS_UP) begin
                            next_st.amp1 = step_amp(st.amp1, pamp_mem[`PMS_PROF_ONE], st.rstep, 1'b1);
                        end else begin
                            next_st.amp1 = step_amp(st.amp1, st.asf1, st.fstep, 1'b0);
                        end
                        if (next_st.amp1 == ((st.dir1 == PMS_UP) ? pamp_mem[`PMS_PROF_ONE] : st.asf1)) begin
                            next_st.dir1 = PMS_HOLD;
                        end
                    end
                end
            endcase
        end
        // register writes
        if (wr_in) begin
            if (addr_in == `PMS_ADR_CTRL) begin
                next_st.ctrl = wdata_in[`PMS_CTRL_W-1:0];
            end else if (addr_in == `PMS_ADR_ASF0) begin
                next_st.asf0 = wdata_in[`PMS_AMP_W-1:0];
            end else if (addr_in == `PMS_ADR_ASF1) begin
                next_st.asf1 = wdata_in[`PMS_AMP_W-1:0];
            end else if (addr_in == `PMS_ADR_RSTEP) begin
                next_st.rstep = wdata_in[`PMS_AMP_W-1:0];
            end else if (addr_in == `PMS_ADR_FSTEP) begin
                next_st.fstep = wdata_in[`PMS_AMP_W-1:0];
            end else if (addr_in == `PMS_ADR_RIVL) begin
                next_st.rivl = wdata_in[`PMS_IVL_W-1:0];
            end else if (addr_in == `PMS_ADR_FIVL) begin
                next_st.fivl = wdata_in[`PMS_IVL_W-1:0];
            end
        end
        // register reads, unmapped reads return zero
        next_st.rdata = '0;
        if (rd_in) begin
            if (addr_in == `PMS_ADR_CTRL) begin
                next_st.rdata = 32'(st.ctrl);
            end else if (addr_in == `PMS_ADR_ASF0) begin
                next_st.rdata = 32'(st.asf0);
            end else if (addr_in == `PMS_ADR_ASF1) begin
                next_st.rdata = 32'(st.asf1);
            end else if (addr_in == `PMS_ADR_RSTEP) begin
                next_st.rdata = 32'(st.rstep);
            end else if (addr_in == `PMS_ADR_FSTEP) begin
                next_st.rdata = 32'(st.fstep);
            end else if (addr_in == `PMS_ADR_RIVL) begin
                next_st.rdata = 32'(st.rivl);
            end else if (addr_in == `PMS_ADR_FIVL) begin
                next_st.rdata = 32'(st.fivl);
            end else if (addr_in == `PMS_ADR_STAT) begin
                next_st.rdata = {26'h0, st.dir1, st.dir0};
            end else if (addr_in == `PMS_ADR_INDEX) begin
                next_st.rdata = 32'(st.index);
            end else if (addr_in == `PMS_ADR_AMP0) begin
                next_st.rdata = 32'(st.amp0);
            end else if (addr_in == `PMS_ADR_AMP1) begin
                next_st.rdata = 32'(st.amp1);
            end else if (addr_in == `PMS_ADR_PAMP0 || addr_in == `PMS_ADR_PAMP1) begin
                next_st.rdata = 32'(pamp_mem[addr_in[0] ? 0 : 1]);
            end else if (addr_in >= `PMS_ADR_FTW && addr_in < `PMS_ADR_FTW + 8'(`PMS_NPROF)) begin
                next_st.rdata = 32'(ftw_mem[addr_in[3:0]]);
            end
        end
    end

    // ****************************************
    // registers and outputs
    // ****************************************
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            st      <= '0;
            st.dir0 <= PMS_HOLD;
            st.dir1 <= PMS_HOLD;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_out     = st.rdata;
    assign ftw_out       = st.ftw;
    assign amp0_out      = st.amp0;
    assign amp1_out      = st.amp1;
    assign phase_clr_out = st.pclr;

    // ****************************************
    // checks
    // ****************************************
    sequence pins_all_s;
        st.ctrl[`PMS_BIT_MOD16] && pin_vec == `PMS_IDX_ALL;
    endsequence
    idx_order_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        st.ctrl[`PMS_BIT_MOD16] ##1 st.ctrl[`PMS_BIT_MOD16] |=> st.index == $past(st.pins))
        else $error("profile index does not follow pins");
    idx_all_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        pins_all_s ##1 st.ctrl[`PMS_BIT_MOD16] |=> st.index == `PMS_IDX_ALL)
        else $error("all pins did not select fifteen");
    ftw_sel_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        ##1 ftw_out == $past(ftw_mem[st.index]))
        else $error("tuning word does not match index");
    sweep_off_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        !st.ctrl[`PMS_BIT_SWEEP0] |=> amp0_out == $past(st.asf0))
        else $error("channel 0 swept while disabled");
    sweep_asf_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        st.ctrl[`PMS_BIT_ASFEN] |=> st.dir0 == PMS_HOLD && st.dir1 == PMS_HOLD)
        else $error("sweep ran with scale enable set");
    // the pin may drop at any time; rising needs the pin as sampled one cycle before
    dir_up_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        st.dir0 == PMS_UP |-> $past(st.pins[1]))
        else $error("channel 0 rising without its pin");
    amp_bound_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        st.dir1 == PMS_UP && st.amp1 <= pamp_mem[`PMS_PROF_ONE] |=> amp1_out <= $past(pamp_mem[`PMS_PROF_ONE]))
        else $error("channel 1 passed end point");
    step_rate_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
        st.dir0 == PMS_UP && st.tmr0 < st.rivl ##1 st.dir0 == PMS_UP |-> $stable(amp0_out))
        else $error("channel 0 stepped before interval");
endmodule
`default_nettype wire

/* rtl/pms_defines.svh */
// constants for the profile modulation and sweep controller
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH
`define PMS_FTW_W      32
`define PMS_AMP_W      10
`define PMS_IDX_W      4
`define PMS_NPROF      16
`define PMS_NCH        2
`define PMS_IVL_W      8
`define PMS_ADDR_W     8
`define PMS_IDX_ZERO   4'h0
`define PMS_IDX_ALL    4'hF
`define PMS_PROF_ONE   1
`define PMS_ADR_CTRL   8'h00
`define PMS_ADR_ASF0   8'h01
`define PMS_ADR_ASF1   8'h02
`define PMS_ADR_RSTEP  8'h03
`define PMS_ADR_FSTEP  8'h04
`define PMS_ADR_RIVL   8'h05
`define PMS_ADR_FIVL   8'h06
`define PMS_ADR_STAT   8'h07
`define PMS_ADR_INDEX  8'h08
`define PMS_ADR_AMP0   8'h09
`define PMS_ADR_AMP1   8'h0A
`define PMS_ADR_PAMP0  8'h0B
`define PMS_ADR_PAMP1  8'h0C
`define PMS_ADR_FTW    8'h10
`define PMS_BIT_MOD16  0
`define PMS_BIT_SWEEP0 1
`define PMS_BIT_SWEEP1 2
`define PMS_BIT_ACLRS  3
`define PMS_BIT_ACLRP  4
`define PMS_BIT_ASFEN  5
`define PMS_CTRL_W     6
`endif

/* rtl/pms_pkg.sv */
// types for the profile modulation and sweep controller
`include "pms_defines.svh"
package pms_pkg;
    typedef enum logic [2:0] {
        PMS_HOLD = 3'h1,
        PMS_UP   = 3'h2,
        PMS_DOWN = 3'h4
    } pms_dir_type;
endpackage

/* testbench/pms_pin_driver.sv */
// outside controller model that drives the four profile pins
`timescale 1ns/100ps
`default_nettype none
module pms_pin_driver (
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    input  wire logic [3:0] req_in,
    input  wire logic       slow_in,
    output logic      [3:0] pins_out,
    output logic            match_out
);
    logic [1:0] lag_cnt;

    // slow mode holds off three extra cycles, like a sluggish controller
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pins_out <= 4'h0;
            lag_cnt  <= 2'h0;
        end else if (req_in == pins_out) begin
            lag_cnt <= 2'h0;
        end else if (!slow_in || lag_cnt == 2'h3) begin
            pins_out <= req_in;
            lag_cnt  <= 2'h0;
        end else begin
            lag_cnt <= lag_cnt + 2'h1;
        end
    end

    // pins have caught up with the request
    assign match_out = (req_in == pins_out);
endmodule
`default_nettype wire

/* testbench/pms_ctrl_tb_top.sv */
// self-checking bench for the profile modulation and sweep controller
`timescale 1ns/100ps
`default_nettype none
`include "pms_defines.svh"
module pms_ctrl_tb_top
    import pms_pkg::*;
;
    logic                   mclk_in;
    logic                   reset_n_in;
    logic [3:0]             pin_req;
    logic                   slow;
    logic [3:0]             pins;
    logic                   pins_match;
    logic [`PMS_ADDR_W-1:0] addr_in;
    logic [31:0]            wdata_in;
    logic                   wr_in;
    logic                   rd_in;
    logic [31:0]            rdata_out;
    logic [`PMS_FTW_W-1:0]  ftw_out;
    logic [`PMS_AMP_W-1:0]  amp0_out;
    logic [`PMS_AMP_W-1:0]  amp1_out;
    logic                   phase_clr_out;
    logic [31:0]            prof [0:15];
    logic [3:0]             idx;
    int                     err_count;
    int                     compares;
    int                     seed;
    int                     n;

    pms_pin_driver u_pms_pin_driver (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .req_in(pin_req),
        .slow_in(slow), .pins_out(pins), .match_out(pins_match));
    pms_ctrl u_pms_ctrl (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .profile_pin_0_in(pins[0]),
        .profile_pin_1_in(pins[1]), .profile_pin_2_in(pins[2]), .profile_pin_3_in(pins[3]),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .ftw_out(ftw_out), .amp0_out(amp0_out), .amp1_out(amp1_out), .phase_clr_out(phase_clr_out));

    // 250 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask

    // pin0 is the top index bit, pin3 the bottom one
    function automatic logic [3:0] pins_for(input logic [3:0] i);
        return {i[0], i[1], i[2], i[3]};
    endfunction

    // returns once the pins moved; that edge is the change edge
    task automatic set_pins(input logic [3:0] v);
        int k;
        @(posedge mclk_in);
        pin_req <= v;
        slow    <= 1'($random(seed));
        for (k = 0; k < 20; k++) begin
            @(posedge mclk_in);
            #1;
            if (pins_match) break;
        end
    endtask

    // cycles a sweep needs: whole steps, each one interval plus one long
    function automatic int sweep_cycles(input int span, input int stp, input int ivl);
        return ((span + stp - 1) / stp) * (ivl + 1) + 2;
    endfunction

    task automatic time_sweep(input logic [3:0] v, input bit ch, input logic [9:0] tgt, output int cnt);
        set_pins(v);
        for (cnt = 0; cnt < 1000; cnt++) begin
            @(posedge mclk_in);
            #1;
            if ((ch ? amp1_out : amp0_out) === tgt) break;
        end
    endtask

    // hang guard, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge mclk_in);
        err_count++;
        close_out();
    end

    initial begin
        seed = 8;
        err_count = 0;
        compares = 0;
        reset_n_in = 1'b0;
        pin_req = 4'h0;
        slow = 1'b0;
        addr_in = 8'h00;
        wdata_in = 32'h0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        repeat (12) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        // random tuning words for all sixteen profiles
        for (int i = 0; i < 16; i++) begin
            prof[i] = $random(seed);
            wr_reg(`PMS_ADR_FTW + i[7:0], prof[i]);
        end
        rd_chk(`PMS_ADR_FTW + 8'h05, prof[5]);
        rd_chk(8'h0D, 32'h0); // unmapped place reads zero
        wr_reg(`PMS_ADR_CTRL, 32'h01);
        // corners first, then random codes
        for (int i = 0; i < 14; i++) begin
            idx = (i == 0) ? `PMS_IDX_ZERO : (i == 1) ? `PMS_IDX_ALL : 4'($random(seed));
            set_pins(pins_for(idx));
            repeat (3) @(posedge mclk_in);
            #1;
            chk(ftw_out, prof[idx]);
            rd_chk(`PMS_ADR_INDEX, {28'h0, idx});
        end
        set_pins(4'h0);
        // sweep setup: start 0x200/0x100, end 0x3FF, rise and fall differ
        wr_reg(`PMS_ADR_ASF0, 32'h200);
        wr_reg(`PMS_ADR_ASF1, 32'h100);
        wr_reg(`PMS_ADR_PAMP1, 32'h3FF);
        wr_reg(`PMS_ADR_RSTEP, 32'h40);
        wr_reg(`PMS_ADR_FSTEP, 32'h20);
        wr_reg(`PMS_ADR_RIVL, 32'h3);
        wr_reg(`PMS_ADR_FIVL, 32'h2);
        wr_reg(`PMS_ADR_CTRL, 32'h1E);
        repeat (300) @(posedge mclk_in);
        #1;
        chk({22'h0, amp0_out}, 32'h200);
        chk({22'h0, amp1_out}, 32'h100);
        chk({31'h0, phase_clr_out}, 32'h1);
        rd_chk(`PMS_ADR_STAT, 32'h09);
        // pin2 sweeps channel 0 up, channel 1 stays put
        time_sweep(4'h4, 1'b0, 10'h3FF, n);
        chk({31'h0, n >= sweep_cycles(511, 64, 3) - 6 && n <= sweep_cycles(511, 64, 3) + 6}, 32'h1);
        chk({22'h0, amp1_out}, 32'h100);
        time_sweep(4'h0, 1'b0, 10'h200, n);
        chk({31'h0, n >= sweep_cycles(511, 32, 2) - 6 && n <= sweep_cycles(511, 32, 2) + 6}, 32'h1);
        // pin3 sweeps channel 1 up then back down
        time_sweep(4'h8, 1'b1, 10'h3FF, n);
        chk({22'h0, amp0_out}, 32'h200);
        chk({31'h0, n < 1000}, 32'h1);
        time_sweep(4'h0, 1'b1, 10'h100, n);
        chk({31'h0, n < 1000}, 32'h1);
        // channel 1 enable cleared: pin3 must not move it
        wr_reg(`PMS_ADR_CTRL, 32'h1A);
        set_pins(4'h8);
        repeat (100) @(posedge mclk_in);
        #1;
        chk({22'h0, amp1_out}, 32'h100);
        // scale factor enable set: sweep logic gives up the amplitude
        wr_reg(`PMS_ADR_CTRL, 32'h3E);
        set_pins(4'h4);
        repeat (100) @(posedge mclk_in);
        #1;
        chk({22'h0, amp0_out}, 32'h200);
        set_pins(4'h0);
        wr_reg(`PMS_ADR_CTRL, 32'h0E);
        repeat (4) @(posedge mclk_in);
        #1;
        chk({31'h0, phase_clr_out}, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
